// [verilog/lscp_defines.svh]
// register offsets, field positions and reset values for the status-change block
// assumes: included by bare name from the package and design files
`ifndef LSCP_DEFINES_SVH
`define LSCP_DEFINES_SVH
`define LSCP_ADDR_W 4
`define LSCP_OFF_EVENT 4'h0
`define LSCP_OFF_MASK 4'h4
`define LSCP_OFF_PRESENT 4'h8
`define LSCP_OFF_FORCE 4'hC
`define LSCP_BIT_INT_FLAG 15
`define LSCP_BIT_WAKE_MASK 14
`define LSCP_BIT_GEN_WAKE 4
`define LSCP_RST_EVENT 32'h0000_0000
`define LSCP_RST_MASK 32'h0000_0000
`define LSCP_RST_PRESENT 32'h0000_0000
`endif

// [verilog/lscp_pkg.sv]
// types shared by the status-change block
// assumes: constants come from lscp_defines.svh
`include "lscp_defines.svh"
package lscp_pkg;
    typedef logic [31:0] lscp_word_t;
    typedef logic [`LSCP_ADDR_W-1:0] lscp_addr_t;
endpackage

// [verilog/lscp_status_change.sv]
// network function status-change block: event, mask, present-state and force-event
// assumes: synchronous register port, single 100 MHz clock, sources synchronous
`timescale 1ns/100ps
`include "lscp_defines.svh"
module lscp_status_change (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire lscp_pkg::lscp_addr_t addr_i,
    input wire lscp_pkg::lscp_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output lscp_pkg::lscp_word_t rdata_o,
    input wire logic eth_int_pending_i,
    input wire logic [2:0] power_mgmt_driver_reg_i,
    input wire logic link_wake_en_i,
    input wire logic frame_wake_dis_i,
    input wire logic filter_wake_en_i,
    input wire logic system_control_block_int_en_i,
    input wire logic pme_en_i,
    output logic int_o,
    output logic cstschg_o
);
    // bits of the driver register: [2] link change, [1] wake frame, [0] interesting frame
    logic general_wake_live;
    logic wr_event;
    logic wr_mask;
    logic wr_force;
    logic wr_present;
    logic rd_present;
    logic [31:0] event_reg;
    logic [31:0] mask_reg;
    logic [31:0] event_next;
    lscp_pkg::lscp_word_t present_word;
    lscp_pkg::lscp_word_t rdata_next;

    // address decode, shared by strobes, read mux and checks
    function automatic logic hit(input lscp_pkg::lscp_addr_t a, input lscp_pkg::lscp_addr_t off);
        hit = (a == off);
    endfunction

    // gated wake sources folded into one level
    function automatic logic wake_of(input logic [2:0] flags, input logic link_en,
                                     input logic frame_dis, input logic filt_en);
        wake_of = (flags[2] & link_en)
                | (flags[1] & ~frame_dis)
                | (flags[0] & filt_en);
    endfunction

    assign general_wake_live = wake_of(power_mgmt_driver_reg_i, link_wake_en_i,
                                       frame_wake_dis_i, filter_wake_en_i);

    always_comb begin
        present_word = 32'h0000_0000;
        present_word[`LSCP_BIT_INT_FLAG] = eth_int_pending_i;
        present_word[`LSCP_BIT_GEN_WAKE] = general_wake_live;
    end

    assign wr_event = ce_i & wr_i & hit(addr_i, `LSCP_OFF_EVENT);
    assign wr_mask = ce_i & wr_i & hit(addr_i, `LSCP_OFF_MASK);
    assign wr_force = ce_i & wr_i & hit(addr_i, `LSCP_OFF_FORCE);
    // present word is read only; its write strobe goes nowhere
    assign wr_present = ce_i & wr_i & hit(addr_i, `LSCP_OFF_PRESENT);
    assign rd_present = ce_i & rd_i & hit(addr_i, `LSCP_OFF_PRESENT);

    // latched events: sources and forces set, write-one clears once serviced; set wins
    always_comb begin
        event_next = event_reg;
        if (wr_event) begin
            if (wdata_i[`LSCP_BIT_INT_FLAG] && !eth_int_pending_i) begin
                event_next[`LSCP_BIT_INT_FLAG] = 1'b0;
            end
            if (wdata_i[`LSCP_BIT_GEN_WAKE] && !general_wake_live) begin
                event_next[`LSCP_BIT_GEN_WAKE] = 1'b0;
            end
        end
        if (eth_int_pending_i) begin
            event_next[`LSCP_BIT_INT_FLAG] = 1'b1;
        end
        if (general_wake_live) begin
            event_next[`LSCP_BIT_GEN_WAKE] = 1'b1;
        end
        if (wr_force && wdata_i[`LSCP_BIT_INT_FLAG]) begin
            event_next[`LSCP_BIT_INT_FLAG] = 1'b1;
        end
        if (wr_force && wdata_i[`LSCP_BIT_GEN_WAKE]) begin
            event_next[`LSCP_BIT_GEN_WAKE] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_reg <= `LSCP_RST_EVENT;
        end else if (ce_i) begin
            event_reg <= event_next;
        end
    end

    // only the three mask bits are kept; the rest read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `LSCP_RST_MASK;
        end else if (wr_mask) begin
            mask_reg <= 32'h0000_0000;
            mask_reg[`LSCP_BIT_INT_FLAG] <= wdata_i[`LSCP_BIT_INT_FLAG];
            mask_reg[`LSCP_BIT_WAKE_MASK] <= wdata_i[`LSCP_BIT_WAKE_MASK];
            mask_reg[`LSCP_BIT_GEN_WAKE] <= wdata_i[`LSCP_BIT_GEN_WAKE];
        end
    end

    // read data one cycle after strobe; present and force reads have no side effect
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(addr_i, `LSCP_OFF_EVENT)) begin
            rdata_next = event_reg;
        end else if (hit(addr_i, `LSCP_OFF_MASK)) begin
            rdata_next = mask_reg;
        end else if (hit(addr_i, `LSCP_OFF_PRESENT)) begin
            rdata_next = present_word;
        end
    end

    // read data stand one enabled cycle, zero otherwise; a frozen clock enable holds them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end

    // level outputs from latched events through the masks and enables; pme_en_i bypasses the wake masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_o <= 1'b0;
        end else if (ce_i) begin
            int_o <= event_next[`LSCP_BIT_INT_FLAG] & mask_reg[`LSCP_BIT_INT_FLAG]
                   & system_control_block_int_en_i;
        end
    end

    // either both wake masks or the pme enable alone open the line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cstschg_o <= 1'b0;
        end else if (ce_i) begin
            cstschg_o <= event_next[`LSCP_BIT_GEN_WAKE]
                       & ((mask_reg[`LSCP_BIT_WAKE_MASK] & mask_reg[`LSCP_BIT_GEN_WAKE])
                       | pme_en_i);
        end
    end

    // checks of the register word, the latch and the two lines
    sequence s_read_present;
        rd_present;
    endsequence

    sequence s_force_int;
        wr_force && wdata_i[15];
    endsequence

    sequence s_force_wake;
        wr_force && wdata_i[4];
    endsequence

    property p_present_int;
        @(posedge clk_i) disable iff (rst_i)
        s_read_present |=> rdata_o[15] == $past(eth_int_pending_i);
    endproperty
    a_present_int: assert property (p_present_int) else $error("present int wrong");

    property p_present_int_drop;
        @(posedge clk_i) disable iff (rst_i)
        s_read_present ##0 !eth_int_pending_i |=> !rdata_o[15];
    endproperty
    a_present_int_drop: assert property (p_present_int_drop) else $error("present int stuck");

    property p_present_wake;
        @(posedge clk_i) disable iff (rst_i)
        s_read_present |=> rdata_o[4] == $past(general_wake_live);
    endproperty
    a_present_wake: assert property (p_present_wake) else $error("present wake wrong");

    property p_present_wake_idle;
        @(posedge clk_i) disable iff (rst_i)
        s_read_present ##0 (!(power_mgmt_driver_reg_i[2] && link_wake_en_i)
            && !(power_mgmt_driver_reg_i[1] && !frame_wake_dis_i)
            && !(power_mgmt_driver_reg_i[0] && filter_wake_en_i)) |=> !rdata_o[4];
    endproperty
    a_present_wake_idle: assert property (p_present_wake_idle) else $error("present wake spurious");

    property p_link_wake;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && power_mgmt_driver_reg_i[2] && link_wake_en_i |=> event_reg[4];
    endproperty
    a_link_wake: assert property (p_link_wake) else $error("link wake lost");

    property p_frame_wake;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && power_mgmt_driver_reg_i[1] && !frame_wake_dis_i |=> event_reg[4];
    endproperty
    a_frame_wake: assert property (p_frame_wake) else $error("frame wake lost");

    property p_filter_wake;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && power_mgmt_driver_reg_i[0] && filter_wake_en_i |=> event_reg[4];
    endproperty
    a_filter_wake: assert property (p_filter_wake) else $error("filter wake lost");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        rdata_o[31:16] == 16'h0000 && rdata_o[13:5] == 9'h000 && rdata_o[3:0] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_latch_reserved;
        @(posedge clk_i) disable iff (rst_i)
        event_reg[31:16] == 16'h0000 && event_reg[14:5] == 10'h000 && event_reg[3:0] == 4'h0;
    endproperty
    a_latch_reserved: assert property (p_latch_reserved) else $error("latch reserved set");

    property p_force_int;
        @(posedge clk_i) disable iff (rst_i)
        s_force_int |=> event_reg[15];
    endproperty
    a_force_int: assert property (p_force_int) else $error("forced int lost");

    property p_force_wake;
        @(posedge clk_i) disable iff (rst_i)
        s_force_wake |=> event_reg[4];
    endproperty
    a_force_wake: assert property (p_force_wake) else $error("forced wake lost");

    property p_int_line;
        @(posedge clk_i) disable iff (rst_i)
        s_force_int ##0 (mask_reg[15] && system_control_block_int_en_i) |=> int_o;
    endproperty
    a_int_line: assert property (p_int_line) else $error("int line missing");

    property p_cst_line;
        @(posedge clk_i) disable iff (rst_i)
        s_force_wake ##0 ((mask_reg[14] && mask_reg[4]) || pme_en_i) |=> cstschg_o;
    endproperty
    a_cst_line: assert property (p_cst_line) else $error("cstschg line missing");

    // a frozen clock enable holds the lines, so gates are judged only on live edges
    property p_int_gate;
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && int_o |-> $past(mask_reg[15]) && $past(system_control_block_int_en_i);
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("int without enables");

    property p_cst_gate;
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && cstschg_o |-> ($past(mask_reg[14]) && $past(mask_reg[4]))
            || $past(pme_en_i);
    endproperty
    a_cst_gate: assert property (p_cst_gate) else $error("cstschg without enables");

    property p_zero_force;
        @(posedge clk_i) disable iff (rst_i)
        wr_force && !wdata_i[15] && !eth_int_pending_i |=> event_reg[15] == $past(event_reg[15]);
    endproperty
    a_zero_force: assert property (p_zero_force) else $error("zero force changed");

    property p_zero_force_wake;
        @(posedge clk_i) disable iff (rst_i)
        wr_force && !wdata_i[4] && !general_wake_live |=> event_reg[4] == $past(event_reg[4]);
    endproperty
    a_zero_force_wake: assert property (p_zero_force_wake) else $error("zero force wake");

    property p_force_mask_kept;
        @(posedge clk_i) disable iff (rst_i)
        wr_force |=> mask_reg == $past(mask_reg);
    endproperty
    a_force_mask_kept: assert property (p_force_mask_kept) else $error("force touched mask");

    property p_clear_int;
        @(posedge clk_i) disable iff (rst_i)
        wr_event && wdata_i[15] && !eth_int_pending_i |=> !event_reg[15];
    endproperty
    a_clear_int: assert property (p_clear_int) else $error("int not cleared");

    property p_clear_wake_busy;
        @(posedge clk_i) disable iff (rst_i)
        wr_event && wdata_i[4] && general_wake_live |=> event_reg[4];
    endproperty
    a_clear_wake_busy: assert property (p_clear_wake_busy) else $error("wake cleared early");

    property p_clear_zero;
        @(posedge clk_i) disable iff (rst_i)
        wr_event && !wdata_i[15] && event_reg[15] |=> event_reg[15];
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared");

    property p_present_write;
        @(posedge clk_i) disable iff (rst_i)
        wr_present && !eth_int_pending_i && !general_wake_live |=> $stable(event_reg)
            && $stable(mask_reg);
    endproperty
    a_present_write: assert property (p_present_write) else $error("present write took");

    property p_read_stands;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !rd_i |=> rdata_o == 32'h0000_0000;
    endproperty
    a_read_stands: assert property (p_read_stands) else $error("read data lingers");

    property p_reset_values;
        @(posedge clk_i)
        rst_i |=> rdata_o == 32'h0000_0000 && !int_o && !cstschg_o
            && event_reg == `LSCP_RST_EVENT && mask_reg == `LSCP_RST_MASK;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_freeze;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(event_reg) && $stable(mask_reg) && $stable(rdata_o)
            && $stable(int_o) && $stable(cstschg_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// [bench/lscp_host_model.sv]
// host side model: live interrupt and wake sources, configuration gates
// assumes: shares the block clock; every output changes just after the edge
`timescale 1ns/100ps
module lscp_host_model (
    input wire logic clk_i,
    output logic eth_o = 1'b0,
    output logic [2:0] drv_flags_o = 3'h0,
    output logic link_en_o = 1'b0,
    output logic dis_o = 1'b0,
    output logic filt_o = 1'b0,
    output logic ctl_en_o = 1'b0,
    output logic pme_o = 1'b0
);
    integer seed = 32'h9D75;
    // sparse sources so latched bits can be cleared
    always @(posedge clk_i) begin
        eth_o <= ($random(seed) & 7) == 0;
        drv_flags_o <= 3'($random(seed) & $random(seed) & $random(seed));
        {link_en_o, dis_o, filt_o, ctl_en_o, pme_o} <= 5'($random(seed));
    end
endmodule

// [bench/lscp_status_change_tb.sv]
// bench top: random register traffic and live sources against a reference model
// assumes: design files and lscp_host_model compiled first
`timescale 1ns/100ps
module lscp_status_change_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ce_i = 1'b1;
    lscp_pkg::lscp_addr_t addr_i = 4'h0;
    lscp_pkg::lscp_word_t wdata_i = 32'h0;
    lscp_pkg::lscp_word_t rdata_o;
    logic eth, link_en, dis, filt, ctl_en, pme, int_o, cstschg_o;
    logic [2:0] drv_flags;
    logic [3:0] amap [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    integer seed = 32'h9D75;
    integer bad_count = 0;
    integer checks = 0;
    integer k, op, pres, nxt;
    integer ev = 0, mk = 0, rd_exp = 0, int_exp = 0, cst_exp = 0;

    lscp_status_change dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .eth_int_pending_i(eth), .power_mgmt_driver_reg_i(drv_flags),
        .link_wake_en_i(link_en), .frame_wake_dis_i(dis), .filter_wake_en_i(filt),
        .system_control_block_int_en_i(ctl_en),
        .pme_en_i(pme), .int_o(int_o), .cstschg_o(cstschg_o));
    lscp_host_model host_u (.clk_i(clk_i), .eth_o(eth), .drv_flags_o(drv_flags),
        .link_en_o(link_en), .dis_o(dis), .filt_o(filt), .ctl_en_o(ctl_en), .pme_o(pme));

    task automatic print_verdict;
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // reference model: compare last edge's results, then advance
    always @(posedge clk_i) begin
        if (rst_i) begin
            ev = 0;
            mk = 0;
            rd_exp = 0;
            int_exp = 0;
            cst_exp = 0;
        end else begin
            chk("rdata_o", rd_exp, rdata_o);
            chk("int_o", int_exp, int_o);
            chk("cstschg_o", cst_exp, cstschg_o);
            if (ce_i) begin
                pres = (eth << 15) | ((drv_flags[2] & link_en | drv_flags[1] & !dis
                    | drv_flags[0] & filt) << 4);
                rd_exp = !rd_i ? 0 : addr_i == 4'h0 ? ev : addr_i == 4'h4 ? mk :
                    addr_i == 4'h8 ? pres : 0;
                nxt = ev;
                if (wr_i && addr_i == 4'h0)
                    nxt = nxt & ~(wdata_i & ~pres & 32'h8010);
                if (wr_i && addr_i == 4'hC)
                    nxt = nxt | (wdata_i & 32'h8010);
                nxt = nxt | pres;
                int_exp = nxt[15] & mk[15] & ctl_en;
                cst_exp = nxt[4] & (mk[14] & mk[4] | pme);
                if (wr_i && addr_i == 4'h4)
                    mk = wdata_i & 32'hC010;
                ev = nxt;
            end
        end
    end

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // random accesses over every offset plus an unmapped one, reset again mid-run
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 4000; k++) begin
            @(posedge clk_i);
            op = $unsigned($random(seed)) % 3;
            wr_i <= op == 1;
            rd_i <= op == 2;
            addr_i <= amap[$unsigned($random(seed)) % 5];
            wdata_i <= $random(seed);
            ce_i <= ($random(seed) & 7) != 0;
            rst_i <= k >= 2000 && k < 2005;
        end
        @(posedge clk_i);
        print_verdict();
    end

    initial begin
        #60000;
        bad_count++;
        print_verdict();
    end
endmodule
